// *** shared/ext_bus_cfg.svh ***
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH
`define EB_MODE_SINGLE  3'd0
`define EB_MODE_D16_DMX 3'd1
`define EB_MODE_D16_MUX 3'd2
`define EB_MODE_D8_MUX  3'd3
`define EB_MODE_D8_DMX  3'd4
`define EB_SEG_64K  2'd0
`define EB_SEG_256K 2'd1
`define EB_SEG_1M   2'd2
`define EB_SEG_4M   2'd3
`define EB_CFG_RESET 13'h0000
`define EB_ERAM_BASE 24'h00e000
`define EB_ERAM_MASK 24'hfff800
`define EB_SEG_LO 16
`define EB_SEG_HI 21
`define EB_SEG_CAN_HI 19
`define EB_ALE_ONE 4'h1
`endif

// *** shared/ext_bus_pkg.sv ***
`default_nettype none
package ext_bus_pkg;
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] segSize;
    logic [3:0] cycleWait;
    logic       triWait;
    logic       aleLong;
    logic       rwDelay;
    logic       csEnable;
  } bus_cfg_s;
  typedef struct packed {
    logic [23:0] base;
    logic [23:0] mask;
    logic        enable;
  } window_sel_s;
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        write;
    logic        byteAcc;
  } bus_req_s;
endpackage
`default_nettype wire

// *** rtl/window_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_cfg.svh"
module window_decode
  import ext_bus_pkg::*;
(
  input  wire logic        [23:0] addr,
  input  wire window_sel_s [3:0]  windowAddressSelect,
  input  wire bus_cfg_s    [4:0]  busConfig,
  output logic             [4:0]  hit,
  output bus_cfg_s                selCfg
);
  logic [3:0] match;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gMatch
      assign match[g] = windowAddressSelect[g].enable &&
        ((addr & windowAddressSelect[g].mask) ==
         (windowAddressSelect[g].base & windowAddressSelect[g].mask));
    end
  endgenerate
  always_comb begin
    hit    = 5'h00;
    selCfg = busConfig[0];
    if (match[3]) begin
      hit[4] = 1'b1;
      selCfg = busConfig[4];
    end else if (match[2]) begin
      hit[3] = 1'b1;
      selCfg = busConfig[3];
    end else if (match[1]) begin
      hit[2] = 1'b1;
      selCfg = busConfig[2];
    end else if (match[0]) begin
      hit[1] = 1'b1;
      selCfg = busConfig[1];
    end else begin
      hit[0] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** rtl/ext_bus_unit.sv ***
// Notes on behaviour
// - Single-chip mode plus four external modes of 8/16-bit data, muxed or demuxed.
// - Demuxed modes put the address on the address port and data on the full or low-byte port.
// - Muxed modes share one port for address phase and data phase.
// - Cycle time, tri-state time, latch pulse length and read/write delay are programmable.
// - Four address windows each apply their own bus configuration.
// - Window 4 beats window 3 and window 2 beats window 1 on overlap.
// - Addresses outside all windows use the default configuration.
// - Four active-low chip selects, three for windows and one for the default region.
// - The unlatched chip-select bit makes chip selects follow the address directly.
// - Segment lines are six, four, two or none for 4M, 1M, 256K or 64K spaces.
// - With CAN on the segment port only address bits 19 to 16 are driven.
// - The peripheral enable bit decides whether extension RAM is mapped at all.
// - Extension RAM is 2 KByte, full-speed 16-bit, reached without any external bus cycle or strobe.
// - Up to 4 MByte of external memory can be attached.
// - Any address of the 16 MByte space may be read or written by byte, or by word except over an 8-bit external bus, which moves only the low byte.
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_cfg.svh"
module ext_bus_unit
  import ext_bus_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire bus_req_s           req,
  input  wire logic               reqValid,
  output logic                    reqReady,
  output logic             [15:0] rdata,
  output logic                    rdataValid,
  input  wire bus_cfg_s    [4:0]  busConfig,
  input  wire window_sel_s [3:0]  windowAddressSelect,
  input  wire logic               chipSelectUnlatchedCfg,
  input  wire logic               xbusPeriphEnable,
  input  wire logic               canOnSegPort,
  output logic             [15:0] sharedDataPortOut,
  output logic             [15:0] sharedDataPortOe,
  input  wire logic        [15:0] sharedDataPortIn,
  output logic             [15:0] demuxAddrPort,
  output logic             [5:0]  segAddr,
  output logic             [5:0]  segAddrOe,
  output logic             [3:0]  chipSelectN,
  output logic                    addrLatch,
  output logic                    readN,
  output logic                    writeN,
  output logic                    byteHighN
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_ALE = 6'b000010, S_DLY = 6'b000100,
    S_DATA = 6'b001000, S_TRI = 6'b010000, S_ERAM = 6'b100000
  } state_e;
  state_e      state_q, state_d;
  bus_req_s    req_q, req_d;
  bus_cfg_s    cfg_q, cfg_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [15:0] sync1_q, sync2_q;
  logic [15:0] rdata_q, rdata_d;
  logic        rdv_q, rdv_d;
  logic [3:0]  csn_q, csn_d;
  logic [15:0] dOut_q, dOut_d, dOe_q, dOe_d, aPort_q, aPort_d;
  logic [5:0]  seg_q, seg_d, segOe_q, segOe_d;
  logic        ale_q, ale_d, rdn_q, rdn_d, wrn_q, wrn_d, bhe_q, bhe_d;
  logic [4:0]  hitNow;
  bus_cfg_s    cfgNow;
  logic        ready_q;
  logic [15:0] extRam [0:1023];
  logic [9:0]  xIdx;
  logic        xHit;
  window_decode uDecNow (
    .addr(req.addr), .windowAddressSelect(windowAddressSelect),
    .busConfig(busConfig), .hit(hitNow), .selCfg(cfgNow));
  function automatic logic [5:0] seg_mask(input logic [1:0] sz, input logic can);
    logic [5:0] m;
    m = 6'h00;
    case (sz)
      `EB_SEG_256K: m = 6'h03;
      `EB_SEG_1M:   m = 6'h0f;
      `EB_SEG_4M:   m = 6'h3f;
      default:      m = 6'h00;
    endcase
    if (can) m = m & 6'h0f;
    return m;
  endfunction
  function automatic logic is_mux(input logic [2:0] md);
    return (md == `EB_MODE_D16_MUX) || (md == `EB_MODE_D8_MUX);
  endfunction
  function automatic logic is_8bit(input logic [2:0] md);
    return (md == `EB_MODE_D8_MUX) || (md == `EB_MODE_D8_DMX);
  endfunction
  // Extension RAM vanishes from the map when the peripheral enable is low
  assign xHit = xbusPeriphEnable &&
    ((req.addr & `EB_ERAM_MASK) == `EB_ERAM_BASE);
  assign xIdx = req_q.addr[10:1];
  always_ff @(posedge mclk) begin
    if (state_q == S_ERAM && req_q.write) begin
      if (!req_q.byteAcc || !req_q.addr[0]) extRam[xIdx][7:0] <= req_q.wdata[7:0];
      if (!req_q.byteAcc || req_q.addr[0]) extRam[xIdx][15:8] <= req_q.wdata[15:8];
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end else begin
      sync1_q <= sharedDataPortIn;
      sync2_q <= sync1_q;
    end
  end
  always_comb begin
    state_d = state_q;
    req_d   = req_q;
    cfg_d   = cfg_q;
    cnt_d   = cnt_q;
    rdata_d = rdata_q;
    rdv_d   = 1'b0;
    csn_d   = csn_q;
    dOut_d  = dOut_q;
    dOe_d   = dOe_q;
    aPort_d = aPort_q;
    seg_d   = seg_q;
    segOe_d = segOe_q;
    ale_d   = 1'b0;
    rdn_d   = 1'b1;
    wrn_d   = 1'b1;
    bhe_d   = bhe_q;
    // Unlatched mode follows the live address; filtered mode holds it per cycle
    if (chipSelectUnlatchedCfg)
      csn_d = ~(hitNow[3:0] & {4{cfgNow.csEnable}});
    case (state_q)
      S_IDLE: begin
        // Ready gates the take so the first cycle after reset refuses a request
        if (reqValid && ready_q) begin
          req_d = req;
          cfg_d = cfgNow;
          if (xHit) begin
            state_d = S_ERAM;
          end else if (cfgNow.mode != `EB_MODE_SINGLE) begin
            state_d = S_ALE;
            cnt_d   = cfgNow.aleLong ? `EB_ALE_ONE : 4'h0;
            ale_d   = 1'b1;
            seg_d   = req.addr[`EB_SEG_HI:`EB_SEG_LO] & seg_mask(cfgNow.segSize, canOnSegPort);
            segOe_d = seg_mask(cfgNow.segSize, canOnSegPort);
            bhe_d   = ~(!req.byteAcc || req.addr[0]);
            if (!chipSelectUnlatchedCfg)
              csn_d = ~(hitNow[3:0] & {4{cfgNow.csEnable}});
            if (is_mux(cfgNow.mode)) begin
              dOut_d = req.addr[15:0];
              dOe_d  = 16'hffff;
            end else begin
              aPort_d = req.addr[15:0];
              dOe_d   = 16'h0000;
            end
          end else begin
            rdata_d = 16'h0000;
            rdv_d   = !req.write;
          end
        end
      end
      S_ALE: begin
        // Address stays on the shared port until the strobe ends
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
          ale_d = 1'b1;
        end else begin
          state_d = cfg_q.rwDelay ? S_DLY : S_DATA;
          cnt_d   = cfg_q.cycleWait;
          dOe_d   = 16'h0000;
        end
      end
      S_DLY: begin
        state_d = S_DATA;
      end
      S_DATA: begin
        rdn_d = req_q.write;
        wrn_d = !req_q.write;
        if (req_q.write) begin
          dOut_d = req_q.wdata;
          dOe_d  = is_8bit(cfg_q.mode) ? 16'h00ff : 16'hffff;
        end
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          rdn_d = 1'b1;
          wrn_d = 1'b1;
          dOe_d = 16'h0000;
          if (!req_q.write) begin
            rdata_d = is_8bit(cfg_q.mode) ? {8'h00, sync2_q[7:0]} : sync2_q;
            rdv_d   = 1'b1;
          end
          state_d = cfg_q.triWait ? S_TRI : S_IDLE;
          if (!cfg_q.triWait && !chipSelectUnlatchedCfg) csn_d = 4'hf;
        end
      end
      S_TRI: begin
        state_d = S_IDLE;
        if (!chipSelectUnlatchedCfg) csn_d = 4'hf;
      end
      S_ERAM: begin
        rdata_d = extRam[xIdx];
        rdv_d   = !req_q.write;
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      req_q   <= '0;
      cfg_q   <= `EB_CFG_RESET;
      cnt_q   <= 4'h0;
      rdata_q <= 16'h0000;
      rdv_q   <= 1'b0;
      csn_q   <= 4'hf;
      dOut_q  <= 16'h0000;
      dOe_q   <= 16'h0000;
      aPort_q <= 16'h0000;
      seg_q   <= 6'h00;
      segOe_q <= 6'h00;
      ale_q   <= 1'b0;
      rdn_q   <= 1'b1;
      wrn_q   <= 1'b1;
      bhe_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      req_q   <= req_d;
      cfg_q   <= cfg_d;
      cnt_q   <= cnt_d;
      rdata_q <= rdata_d;
      rdv_q   <= rdv_d;
      csn_q   <= csn_d;
      dOut_q  <= dOut_d;
      dOe_q   <= dOe_d;
      aPort_q <= aPort_d;
      seg_q   <= seg_d;
      segOe_q <= segOe_d;
      ale_q   <= ale_d;
      rdn_q   <= rdn_d;
      wrn_q   <= wrn_d;
      bhe_q   <= bhe_d;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) ready_q <= 1'b0;
    else         ready_q <= (state_d == S_IDLE);
  end
  assign reqReady          = ready_q;
  assign rdata             = rdata_q;
  assign rdataValid        = rdv_q;
  assign chipSelectN       = csn_q;
  assign sharedDataPortOut = dOut_q;
  assign sharedDataPortOe  = dOe_q;
  assign demuxAddrPort     = aPort_q;
  assign segAddr           = seg_q;
  assign segAddrOe         = segOe_q;
  assign addrLatch         = ale_q;
  assign readN             = rdn_q;
  assign writeN            = wrn_q;
  assign byteHighN         = bhe_q;
endmodule
`default_nettype wire

// *** verification/ext_bus_unit_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_bus_unit_monitor (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        reqValid,
  input wire logic        reqReady,
  input wire logic        rdataValid,
  input wire logic [15:0] sharedDataPortOe,
  input wire logic [5:0]  segAddrOe,
  input wire logic [3:0]  chipSelectN,
  input wire logic        addrLatch,
  input wire logic        readN,
  input wire logic        writeN
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_valid_pulse: assert property (rdataValid |=> !rdataValid)
    else $error("read valid longer than one cycle");
  a_take_busy: assert property (addrLatch |-> !reqReady)
    else $error("ready while an external access runs");
  a_rw_excl: assert property (readN || writeN)
    else $error("read and write strobes together");
  a_read_float: assert property (!readN |-> sharedDataPortOe == 16'h0000)
    else $error("data port driven during read");
  a_write_drive: assert property (!writeN |-> sharedDataPortOe[7:0] == 8'hff)
    else $error("data port not driven during write");
  a_seg_size: assert property (segAddrOe inside {6'h00, 6'h03, 6'h0f, 6'h3f})
    else $error("bad segment line count");
  a_cs_single: assert property ($onehot0(~chipSelectN))
    else $error("several chip selects active");
  a_read_answer: assert property ($rose(readN) |-> ##[0:2] rdataValid)
    else $error("no read data after strobe");
  c_read: cover property (rdataValid);
  c_write: cover property (!writeN);
  c_ext_read: cover property (!readN);
  c_take: cover property (reqValid && reqReady);
endmodule
bind ext_bus_unit ext_bus_unit_monitor mon_u (.mclk, .resetn, .reqValid, .reqReady,
  .rdataValid, .sharedDataPortOe, .segAddrOe, .chipSelectN, .addrLatch, .readN, .writeN);
`default_nettype wire

// *** verification/ext_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input  wire logic        mclk,
  input  wire logic        muxed,
  input  wire logic        addrLatch,
  input  wire logic        readN,
  input  wire logic        writeN,
  input  wire logic [15:0] sharedDataPortOut,
  input  wire logic [15:0] demuxAddrPort,
  output logic      [15:0] sharedDataPortIn,
  output logic      [15:0] wrData
);
  logic [15:0] addrQ = 16'h0000;
  logic [15:0] lastQ = 16'h0000;
  always @(posedge mclk) begin
    if (addrLatch) addrQ <= muxed ? sharedDataPortOut : demuxAddrPort;
    if (!writeN) wrData <= sharedDataPortOut;
    if (!readN) lastQ <= addrQ ^ 16'h3c5a;
  end
  // Released bus shows the inverse, so a late sample cannot pass by luck
  assign sharedDataPortIn = !readN ? addrQ ^ 16'h3c5a : ~lastQ;
endmodule
`default_nettype wire

// *** verification/external_bus_controller_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module external_bus_controller_test import ext_bus_pkg::*;;
  typedef struct packed {
    logic [2:0] m; logic [1:0] s; logic a; logic [23:0] ad; logic [3:0] cs; logic [5:0] oe;
  } row_s;
  `define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
  logic mclk, resetn, reqValid, reqReady, rdataValid, chipSelectUnlatchedCfg;
  logic xbusPeriphEnable, canOnSegPort, addrLatch, readN, writeN, byteHighN, muxed, rdSeen;
  logic [15:0] rdata, sharedDataPortOut, sharedDataPortOe, sharedDataPortIn, demuxAddrPort;
  logic [15:0] rdQ, wrData;
  logic clr, byteSel;
  logic [5:0] segAddr, segAddrOe, segSeen, oeSeen;
  logic [3:0] chipSelectN, csSeen;
  logic [2:0] aleCnt;
  bus_req_s req;
  bus_cfg_s [4:0] busConfig;
  window_sel_s [3:0] windowAddressSelect;
  int n_fail, checked;
  row_s rows [5] = '{
    '{3'h1, 2'h3, 1'h0, 24'h100800, 4'hb, 6'h3f}, '{3'h2, 2'h2, 1'h1, 24'h108000, 4'hd, 6'h0f},
    '{3'h3, 2'h1, 1'h0, 24'h230000, 4'h7, 6'h03}, '{3'h4, 2'h0, 1'h1, 24'h012340, 4'he, 6'h00},
    '{3'h1, 2'h3, 1'h0, 24'h300010, 4'hf, 6'h3f}};
  ext_bus_unit dut_u (.mclk, .resetn, .req, .reqValid, .reqReady, .rdata, .rdataValid,
    .busConfig, .windowAddressSelect, .chipSelectUnlatchedCfg, .xbusPeriphEnable,
    .canOnSegPort, .sharedDataPortOut, .sharedDataPortOe, .sharedDataPortIn, .demuxAddrPort,
    .segAddr, .segAddrOe, .chipSelectN, .addrLatch, .readN, .writeN, .byteHighN);
  ext_mem_model mem_u (.mclk, .muxed, .addrLatch, .readN, .writeN, .sharedDataPortOut,
    .demuxAddrPort, .sharedDataPortIn, .wrData);
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    if (rdataValid) rdQ <= rdata;
    if (clr) begin
      rdSeen <= 1'h0;
      csSeen <= 4'hf;
      aleCnt <= 3'h0;
    end else begin
      if (!readN) rdSeen <= 1'h1;
      csSeen <= csSeen & chipSelectN;
      if (addrLatch) aleCnt <= aleCnt + 3'h1;
    end
    if (addrLatch) begin
      segSeen <= segAddr & segAddrOe;
      oeSeen <= segAddrOe;
    end
  end
  function automatic bus_cfg_s cfg(logic [2:0] m, logic [1:0] s, logic a);
    return '{m, s, 4'h3, 1'h0, a, 1'h0, 1'h1};
  endfunction
  function automatic logic [15:0] expd(logic [23:0] ad, logic [2:0] m);
    logic [15:0] d;
    d = ad[15:0] ^ 16'h3c5a;
    return (m == 3'h3 || m == 3'h4) ? {8'h00, d[7:0]} : d;
  endfunction
  task automatic conclude();
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(inout int k);
    @(posedge mclk);
    #1 k++;
    if (k > 60) begin
      n_fail++;
      conclude();
    end
  endtask
  // One access at a time; request held until the edge that takes it
  task automatic access(input logic [23:0] ad, input logic [15:0] wd, input logic wr);
    int k;
    k = 0;
    clr = 1'h1;
    req = '{ad, wd, wr, byteSel};
    reqValid = 1'h1;
    while (reqReady !== 1'h1) tick(k);
    @(posedge mclk);
    #1 reqValid = 1'h0;
    clr = 1'h0;
    while (reqReady !== 1'h1) tick(k);
    tick(k);
  endtask
  initial begin
    mclk = 1'h0; resetn = 1'h0; reqValid = 1'h0; req = '0; n_fail = 0; checked = 0;
    clr = 1'h0; byteSel = 1'h0;
    chipSelectUnlatchedCfg = 1'h0; xbusPeriphEnable = 1'h0; canOnSegPort = 1'h0; muxed = 1'h0;
    busConfig = '{5{cfg(3'h1, 2'h3, 1'h0)}};
    windowAddressSelect = '{'{24'h300000, 24'hff0000, 1'h1}, '{24'h200000, 24'hfc0000, 1'h1},
      '{24'h100000, 24'hfff000, 1'h1}, '{24'h100000, 24'hff0000, 1'h1}};
    repeat (12) @(posedge mclk);
    `CHK(chipSelectN, 4'hf)
    `CHK(segAddrOe, 6'h00)
    #1 resetn = 1'h1;
    repeat (2) @(posedge mclk);
    #1;
    foreach (rows[i]) begin
      busConfig = '{5{cfg(rows[i].m, rows[i].s, rows[i].a)}};
      muxed = rows[i].m inside {3'h2, 3'h3};
      access(rows[i].ad, 16'h0000, 1'h0);
      `CHK(rdQ, expd(rows[i].ad, rows[i].m))
      `CHK(csSeen, rows[i].cs)
      `CHK(oeSeen, rows[i].oe)
      `CHK(segSeen, rows[i].ad[21:16] & rows[i].oe)
      `CHK(aleCnt, {2'h0, rows[i].a} + 3'h1)
    end
    canOnSegPort = 1'h1;
    busConfig = '{5{cfg(3'h1, 2'h3, 1'h0)}};
    muxed = 1'h0;
    access(24'h3f0000, 16'h0000, 1'h0);
    `CHK(oeSeen, 6'h0f)
    canOnSegPort = 1'h0;
    access(24'h100800, 16'ha5c3, 1'h1);
    `CHK(wrData, 16'ha5c3)
    `CHK(byteHighN, 1'h0)
    byteSel = 1'h1;
    access(24'h100800, 16'h0000, 1'h0);
    `CHK(byteHighN, 1'h1)
    byteSel = 1'h0;
    xbusPeriphEnable = 1'h1;
    access(24'h00e010, 16'h1234, 1'h1);
    byteSel = 1'h1;
    access(24'h00e011, 16'hab00, 1'h1);
    byteSel = 1'h0;
    access(24'h00e010, 16'h0000, 1'h0);
    `CHK(rdSeen, 1'h0)
    `CHK(rdQ, 16'hab34)
    xbusPeriphEnable = 1'h0;
    access(24'h00e010, 16'h0000, 1'h0);
    `CHK(rdSeen, 1'h1)
    req.addr = 24'h230000;
    @(posedge mclk);
    #1 `CHK(chipSelectN, 4'hf)
    chipSelectUnlatchedCfg = 1'h1;
    @(posedge mclk);
    #1 `CHK(chipSelectN, 4'h7)
    req.addr = 24'h012340;
    @(posedge mclk);
    #1 `CHK(chipSelectN, 4'he)
    busConfig = '{5{cfg(3'h0, 2'h0, 1'h0)}};
    access(24'h012000, 16'h0000, 1'h0);
    `CHK(rdQ, 16'h0000)
    `CHK(rdSeen, 1'h0)
    chipSelectUnlatchedCfg = 1'h0;
    busConfig = '{5{cfg(3'h1, 2'h3, 1'h0)}};
    req = '{24'h100800, 16'h0000, 1'h0, 1'h0};
    reqValid = 1'h1;
    @(posedge mclk);
    #1 reqValid = 1'h0;
    repeat (2) @(posedge mclk);
    #1 resetn = 1'h0;
    #1 `CHK(readN, 1'h1)
    `CHK(chipSelectN, 4'hf)
    `CHK(reqReady, 1'h0)
    @(posedge mclk);
    #1 resetn = 1'h1;
    @(posedge mclk);
    #1 `CHK(reqReady, 1'h1)
    access(24'h012340, 16'h0000, 1'h0);
    `CHK(rdQ, expd(24'h012340, 3'h1))
    conclude();
  end
endmodule
`default_nettype wire
